// file: hdl/sqk_pkg.sv
package sqk_pkg;
  localparam int DATA_W        = 8;
  localparam int NUM_CS        = 4;
  localparam int DIV_W         = 8;
  localparam int FIFO_DEPTH    = 32;
  localparam logic [7:0] DIV_ONE   = 8'h01;
  localparam logic [7:0] DIV_RESET = 8'h02;
  localparam logic MODE_MASTER_RESET   = 1'b1;
  localparam logic FAULT_DIS_RESET     = 1'b0;
  localparam logic TX_EMPTY_RESET      = 1'b1;
  localparam int CS0_INDEX = 0;
  typedef enum logic [1:0] {
    SQK_IDLE,
    SQK_LOAD,
    SQK_SHIFT,
    SQK_DONE
  } sqk_state_t;
endpackage

// file: hdl/sqk_stream_if.sv
`timescale 1ns/100ps
interface sqk_stream_if #(parameter int W = 8);
  logic [W-1:0] data;
  logic         valid;
  logic         ready;
  modport src (output data, output valid, input ready);
  modport dst (input data, input valid, output ready);
endinterface

// file: hdl/sqk_fifo.sv
`timescale 1ns/100ps
module sqk_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 32
) (
  input  wire logic i_clock,
  input  wire logic i_rst,
  sqk_stream_if.dst s_in,
  sqk_stream_if.src s_out
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0]  mem_reg [DEPTH];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic [AW:0]   cnt_reg;
  logic          push;
  logic          pop;
  assign s_in.ready  = (cnt_reg != (AW+1)'(DEPTH));
  assign s_out.valid = (cnt_reg != '0);
  assign s_out.data  = mem_reg[rd_reg];
  assign push = s_in.valid && s_in.ready;
  assign pop  = s_out.valid && s_out.ready;
  always_ff @(posedge i_clock) begin
    if (push) begin
      mem_reg[wr_reg] <= s_in.data;
    end
  end
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wr_reg <= (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
      end
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// file: hdl/sqk_clkdiv.sv
`timescale 1ns/100ps
module sqk_clkdiv #(
  parameter int DW = 8
) (
  input  wire logic          i_clock,
  input  wire logic          i_rst,
  input  wire logic          i_run,
  input  wire logic [DW-1:0] i_div,
  output logic               o_tick
);
  logic [DW-1:0] cnt_reg;
  always_ff @(posedge i_clock) begin
    if (i_rst || !i_run) begin
      cnt_reg <= '0;
      o_tick  <= 1'b0;
    end else if (cnt_reg + 1'b1 >= i_div) begin
      cnt_reg <= '0;
      o_tick  <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
      o_tick  <= 1'b0;
    end
  end
endmodule

// file: hdl/sqk_top.sv
`timescale 1ns/100ps
module sqk_top #(
  parameter int DATA_W = sqk_pkg::DATA_W,
  parameter int NUM_CS = sqk_pkg::NUM_CS,
  parameter int DIV_W  = sqk_pkg::DIV_W,
  parameter int DEPTH  = sqk_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic                    i_clock,
  input  wire logic                    i_rst,
  // Control
  input  wire logic                    i_enable_cmd,
  input  wire logic                    i_disable_cmd,
  input  wire logic                    i_soft_reset_bit,
  input  wire logic                    i_master_mode,
  input  wire logic                    i_fault_detect_disable,
  input  wire logic [NUM_CS-1:0]       i_chip_select_active,
  input  wire logic [NUM_CS*DIV_W-1:0] i_serial_clock_divisor,
  input  wire logic [NUM_CS-1:0]       i_clock_polarity_select,
  input  wire logic [NUM_CS-1:0]       i_clock_phase_select,
  input  wire logic [NUM_CS-1:0]       i_keep_select_after_transfer,
  input  wire logic [$clog2(NUM_CS)-1:0] i_cs_sel,
  // Transmit holding register write port
  input  wire logic [DATA_W-1:0]       i_thr_data,
  input  wire logic                    i_thr_write,
  // Receive stream
  output logic [DATA_W-1:0]            o_rx_data,
  output logic                         o_rx_valid,
  input  wire logic                    i_rx_ready,
  // SPI pins
  output logic                         o_sck,
  output logic                         o_mosi,
  output logic [NUM_CS-1:0]            o_cs_n,
  input  wire logic                    i_miso,
  input  wire logic                    i_sck,
  input  wire logic                    i_mosi,
  input  wire logic                    i_ss_n,
  output logic                         o_miso,
  output logic                         o_miso_oe_n,
  // Status
  output logic                         o_enabled,
  output logic                         o_transmit_holding_empty,
  output logic                         o_busy,
  output logic                         o_fault_unreliable
);
  ////////////////////////////////////////////////////////////////////////////
  // Enable, soft reset
  logic          en_reg;
  logic          srst;
  assign srst = i_rst || i_soft_reset_bit;
  always_ff @(posedge i_clock) begin
    if (srst) begin
      en_reg <= 1'b0;
    end else if (i_enable_cmd) begin
      en_reg <= 1'b1;
    end else if (i_disable_cmd && i_master_mode) begin
      en_reg <= 1'b0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Transmit path: holding write filter into FIFO
  sqk_stream_if #(.W(DATA_W)) tx_in ();
  sqk_stream_if #(.W(DATA_W)) tx_out ();
  assign tx_in.data  = i_thr_data;
  assign tx_in.valid = i_thr_write && en_reg;
  sqk_fifo #(.W(DATA_W), .DEPTH(DEPTH)) u_fifo (
    .i_clock (i_clock),
    .i_rst   (srst),
    .s_in    (tx_in),
    .s_out   (tx_out)
  );
  ////////////////////////////////////////////////////////////////////////////
  // Transmit occupancy, mirrors the words waiting behind the shifter
  // A write and a load in one cycle leave the count unchanged
  logic                       load;
  logic                       tx_push;
  logic [$clog2(DEPTH+1)-1:0] tx_cnt_reg;
  assign tx_push = tx_in.valid && tx_in.ready;
  always_ff @(posedge i_clock) begin
    if (srst) begin
      tx_cnt_reg <= '0;
    end else if (tx_push && !load) begin
      tx_cnt_reg <= tx_cnt_reg + 1'b1;
    end else if (load && !tx_push) begin
      tx_cnt_reg <= tx_cnt_reg - 1'b1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Empty flag: set when the last waiting word moves into the shifter
  logic thr_empty_reg;
  logic tx_last;
  assign tx_last = load && !tx_push && (tx_cnt_reg == ($bits(tx_cnt_reg))'(1));
  always_ff @(posedge i_clock) begin
    if (srst) begin
      thr_empty_reg <= sqk_pkg::TX_EMPTY_RESET;
    end else if (tx_last) begin
      thr_empty_reg <= 1'b1;
    end else if (tx_push) begin
      thr_empty_reg <= 1'b0;
    end
  end
  // Disable does not touch the flag; it only holds otherwise
  ////////////////////////////////////////////////////////////////////////////
  // Clock configuration for the selected chip select; divisor mix over all active selects, stall from select 0
  logic [DIV_W-1:0] div_sel;
  logic             clock_polarity_select;
  logic             clock_phase_select;
  logic             mix_div;
  logic             any_one;
  logic             any_other;
  assign div_sel = i_serial_clock_divisor[i_cs_sel*DIV_W +: DIV_W];
  assign clock_polarity_select    = i_clock_polarity_select[i_cs_sel];
  assign clock_phase_select   = i_clock_phase_select[i_cs_sel];
  always_comb begin
    any_one   = 1'b0;
    any_other = 1'b0;
    for (int k = 0; k < NUM_CS; k++) begin
      if (i_chip_select_active[k]) begin
        if (i_serial_clock_divisor[k*DIV_W +: DIV_W] == DIV_W'(sqk_pkg::DIV_ONE)) begin
          any_one = 1'b1;
        end else begin
          any_other = 1'b1;
        end
      end
    end
    mix_div = any_one && any_other && clock_polarity_select && !clock_phase_select;
  end
  logic hang;
  assign hang = i_keep_select_after_transfer[sqk_pkg::CS0_INDEX]
                && !i_fault_detect_disable;
  ////////////////////////////////////////////////////////////////////////////
  // Master shifter
  sqk_pkg::sqk_state_t state_reg;
  logic [DATA_W-1:0]   sh_reg;
  logic [$clog2(DATA_W*2+2)-1:0] edge_reg;
  logic                tick;
  logic                glitch_reg;
  logic [DATA_W-1:0]   rx_sh_reg;
  logic                run;
  assign run  = (state_reg == sqk_pkg::SQK_SHIFT) || (state_reg == sqk_pkg::SQK_LOAD);
  assign load = (state_reg == sqk_pkg::SQK_IDLE) && en_reg && i_master_mode
                && tx_out.valid && !hang;
  assign tx_out.ready = load;
  sqk_clkdiv #(.DW(DIV_W)) u_div (
    .i_clock (i_clock),
    .i_rst   (srst),
    .i_run   (run),
    .i_div   (div_sel),
    .o_tick  (tick)
  );
  sqk_stream_if #(.W(DATA_W)) rx_in ();
  sqk_stream_if #(.W(DATA_W)) rx_out ();
  logic rx_push_reg;
  logic [DATA_W-1:0] rx_word_reg;
  assign rx_in.data  = rx_word_reg;
  assign rx_in.valid = rx_push_reg;
  assign rx_out.ready = i_rx_ready || !o_rx_valid;
  sqk_fifo #(.W(DATA_W), .DEPTH(DEPTH)) u_rx_fifo (
    .i_clock (i_clock),
    .i_rst   (srst),
    .s_in    (rx_in),
    .s_out   (rx_out)
  );
  always_ff @(posedge i_clock) begin
    if (srst) begin
      state_reg  <= sqk_pkg::SQK_IDLE;
      sh_reg     <= '0;
      edge_reg   <= '0;
      glitch_reg <= 1'b0;
      o_sck      <= 1'b0;
      o_mosi     <= 1'b0;
      o_cs_n     <= '1;
      rx_sh_reg  <= '0;
    end else begin
      case (state_reg)
        sqk_pkg::SQK_IDLE: begin
          o_sck <= clock_polarity_select;
          if (load) begin
            sh_reg    <= tx_out.data;
            state_reg <= sqk_pkg::SQK_LOAD;
            o_cs_n    <= ~(NUM_CS'(1) << i_cs_sel);
            glitch_reg <= mix_div;
          end else if (!i_keep_select_after_transfer[i_cs_sel]) begin
            o_cs_n <= '1;
          end
        end
        sqk_pkg::SQK_LOAD: begin
          edge_reg  <= '0;
          o_mosi    <= sh_reg[DATA_W-1];
          state_reg <= sqk_pkg::SQK_SHIFT;
        end
        sqk_pkg::SQK_SHIFT: begin
          if (tick) begin
            if (glitch_reg) begin
              o_sck      <= ~o_sck;
              glitch_reg <= o_sck == clock_polarity_select ? 1'b1 : 1'b0;
              if (o_sck != clock_polarity_select) begin
                glitch_reg <= 1'b0;
              end
            end else begin
              o_sck    <= ~o_sck;
              edge_reg <= edge_reg + 1'b1;
              if (edge_reg[0] == clock_phase_select) begin
                rx_sh_reg <= {rx_sh_reg[DATA_W-2:0], i_miso};
              end else begin
                sh_reg <= {sh_reg[DATA_W-2:0], 1'b0};
                o_mosi <= sh_reg[DATA_W-2];
              end
              if (edge_reg == ($bits(edge_reg))'(DATA_W*2-1)) begin
                state_reg <= sqk_pkg::SQK_DONE;
              end
            end
          end
        end
        sqk_pkg::SQK_DONE: begin
          o_sck     <= clock_polarity_select;
          state_reg <= sqk_pkg::SQK_IDLE;
        end
        default: state_reg <= sqk_pkg::SQK_IDLE;
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Slave shifter; keeps running regardless of disable
  logic              sck_d_reg;
  logic [$clog2(DATA_W+1)-1:0] sbit_reg;
  logic [DATA_W-1:0] srx_reg;
  logic              slave_on;
  assign slave_on = en_reg && !i_master_mode;
  always_ff @(posedge i_clock) begin
    if (srst) begin
      sck_d_reg   <= 1'b0;
      sbit_reg    <= '0;
      srx_reg     <= '0;
      o_miso      <= 1'b0;
      o_miso_oe_n <= 1'b1;
    end else begin
      sck_d_reg   <= i_sck;
      o_miso_oe_n <= !(slave_on && !i_ss_n);
      o_miso      <= 1'b0;
      if (!slave_on || i_ss_n) begin
        sbit_reg <= '0;
      end else if (i_sck && !sck_d_reg) begin
        srx_reg  <= {srx_reg[DATA_W-2:0], i_mosi};
        sbit_reg <= (sbit_reg == ($bits(sbit_reg))'(DATA_W-1)) ? '0 : sbit_reg + 1'b1;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Receive word capture and outputs
  always_ff @(posedge i_clock) begin
    if (srst) begin
      rx_push_reg <= 1'b0;
      rx_word_reg <= '0;
    end else begin
      rx_push_reg <= 1'b0;
      if (state_reg == sqk_pkg::SQK_DONE) begin
        rx_word_reg <= rx_sh_reg;
        rx_push_reg <= 1'b1;
      end else if (slave_on && !i_ss_n && i_sck && !sck_d_reg
                   && sbit_reg == ($bits(sbit_reg))'(DATA_W-1)) begin
        rx_word_reg <= {srx_reg[DATA_W-2:0], i_mosi};
        rx_push_reg <= 1'b1;
      end
    end
  end
  always_ff @(posedge i_clock) begin
    if (srst) begin
      o_rx_data  <= '0;
      o_rx_valid <= 1'b0;
      o_enabled  <= 1'b0;
      o_transmit_holding_empty <= sqk_pkg::TX_EMPTY_RESET;
      o_busy     <= 1'b0;
      o_fault_unreliable <= 1'b0;
    end else begin
      if (rx_out.valid && rx_out.ready) begin
        o_rx_data  <= rx_out.data;
        o_rx_valid <= 1'b1;
      end else if (i_rx_ready) begin
        o_rx_valid <= 1'b0;
      end
      o_enabled  <= en_reg;
      o_transmit_holding_empty <= thr_empty_reg;
      o_busy     <= run || (state_reg == sqk_pkg::SQK_DONE);
      o_fault_unreliable <= !i_fault_detect_disable;
    end
  end
endmodule

// file: dv/sqk_top_properties.sv
`timescale 1ns/100ps
module sqk_top_props #(
  parameter int NUM_CS = 4
) (
  input wire logic              i_clock,
  input wire logic              i_rst,
  input wire logic              i_enable_cmd,
  input wire logic              i_disable_cmd,
  input wire logic              i_soft_reset_bit,
  input wire logic              i_master_mode,
  input wire logic              i_fault_detect_disable,
  input wire logic [NUM_CS-1:0] i_keep_select_after_transfer,
  input wire logic              i_thr_write,
  input wire logic              o_enabled,
  input wire logic              o_transmit_holding_empty,
  input wire logic              o_busy,
  input wire logic              o_fault_unreliable
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);
  logic stall;
  assign stall = i_keep_select_after_transfer[0] & ~i_fault_detect_disable;
  a_slave_stays_on: assert property (
    o_enabled && !i_master_mode && i_disable_cmd && !i_soft_reset_bit |-> ##2 o_enabled)
    else $error("slave disable took effect");
  a_master_turns_off: assert property (
    i_master_mode && i_disable_cmd && !i_enable_cmd |-> ##2 !o_enabled)
    else $error("master disable ignored");
  a_soft_reset_clears: assert property (
    i_soft_reset_bit |-> ##2 (!o_enabled && o_transmit_holding_empty))
    else $error("soft reset incomplete");
  a_stall_no_start: assert property (
    stall && $past(stall) && $past(stall, 2) && !o_busy |=> !o_busy)
    else $error("transfer began while stalled");
  a_disable_keeps_flag: assert property (
    i_disable_cmd && !i_thr_write && !$past(i_thr_write) && !$past(i_thr_write, 2)
    && !i_soft_reset_bit |-> $stable(o_transmit_holding_empty)[*3])
    else $error("disable moved empty flag");
  a_drop_write_off: assert property (
    !o_enabled && !$past(o_enabled) && !i_enable_cmd && !$past(i_enable_cmd)
    && o_transmit_holding_empty && i_thr_write |=> o_transmit_holding_empty[*3])
    else $error("write accepted while disabled");
  a_fault_flag_on: assert property (
    !i_fault_detect_disable && !i_soft_reset_bit |=> o_fault_unreliable)
    else $error("fault flag low with detect on");
  a_fault_flag_off: assert property (
    i_fault_detect_disable |=> !o_fault_unreliable)
    else $error("fault flag high with detect off");
  a_flag_fall_cause: assert property (
    $fell(o_transmit_holding_empty) |-> $past(i_thr_write, 2) || $past(i_thr_write, 3))
    else $error("empty flag fell without write");
endmodule

// file: dv/sqk_peer_slave.sv
`timescale 1ns/100ps
module sqk_peer_slave #(
  parameter int NUM_CS = 4
) (
  input  wire logic              i_clock,
  input  wire logic [NUM_CS-1:0] i_cs_n,
  input  wire logic              i_sck,
  input  wire logic              i_mosi,
  output logic                   o_miso,
  output logic [15:0]            o_frames,
  output logic [7:0]             o_word,
  output logic                   o_word_stb
);
  logic       sck_d_reg = 1'b0;
  logic [2:0] bits_reg  = 3'h0;
  logic       idle_reg  = 1'b0;
  initial o_frames   = 16'h0000;
  initial o_word     = 8'h00;
  initial o_word_stb = 1'b0;
  // Constant bit per word, alternating; a deselected line toggles every cycle
  assign o_miso = (~&i_cs_n) ? o_frames[0] : idle_reg;
  // Words are counted on rising serial clock edges, most significant bit first
  always @(posedge i_clock) begin
    sck_d_reg  <= i_sck;
    idle_reg   <= ~o_miso;
    o_word_stb <= 1'b0;
    if (&i_cs_n) begin
      bits_reg <= 3'h0;
    end else if (i_sck && !sck_d_reg) begin
      o_word   <= {o_word[6:0], i_mosi};
      bits_reg <= bits_reg + 3'h1;
      if (bits_reg == 3'h7) begin
        o_frames   <= o_frames + 16'h0001;
        o_word_stb <= 1'b1;
      end
    end
  end
endmodule

// file: dv/test_spi_port_revision_quirks.sv
`timescale 1ns/100ps
module test_spi_port_revision_quirks;
  logic        i_clock, i_rst, i_enable_cmd, i_disable_cmd, i_soft_reset_bit;
  logic        i_master_mode, i_fault_detect_disable, i_thr_write, i_rx_ready;
  logic        i_miso, i_sck, i_mosi, i_ss_n, sck_q;
  logic [3:0]  i_chip_select_active, i_clock_polarity_select, i_clock_phase_select;
  logic [3:0]  i_keep_select_after_transfer, o_cs_n;
  logic [31:0] i_serial_clock_divisor;
  logic [31:0] seed = 32'h0E5C;
  logic [1:0]  i_cs_sel;
  logic [7:0]  i_thr_data, o_rx_data;
  logic        o_rx_valid, o_sck, o_mosi, o_miso, o_miso_oe_n, o_enabled;
  logic        o_transmit_holding_empty, o_busy, o_fault_unreliable, mo_stb;
  logic [15:0] frames, base;
  logic [7:0]  rx_q[$], wr_q[$], mo_q[$], sb, mo_word;
  int          errors, samples_checked, tog, k;

  sqk_top dut (.*);
  sqk_peer_slave u_peer (.i_clock(i_clock), .i_cs_n(o_cs_n), .i_sck(o_sck), .i_mosi(o_mosi),
    .o_miso(i_miso), .o_frames(frames), .o_word(mo_word), .o_word_stb(mo_stb));
  initial i_clock = 1'b0;
  always #5 i_clock = ~i_clock;
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  always @(negedge i_clock) begin
    seed <= lfsr(seed);
    i_rx_ready <= seed[3];
  end
  always @(posedge i_clock) begin
    sck_q <= o_sck;
    if (o_sck !== sck_q) tog <= tog + 1;
    if (!i_rst && o_rx_valid === 1'b1 && i_rx_ready === 1'b1) rx_q.push_back(o_rx_data);
    if (!i_rst && mo_stb === 1'b1) mo_q.push_back(mo_word);
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("Checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic check_bit(string what, logic exp, logic got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic check_val(string what, logic [15:0] exp, logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(negedge i_clock);
  endtask
  task automatic wr(int n);
    repeat (n) begin
      i_thr_data = seed[15:8];
      i_thr_write = 1'b1;
      wr_q.push_back(i_thr_data);
      cyc(1);
    end
    i_thr_write = 1'b0;
  endtask
  task automatic pulse_en();
    i_enable_cmd = 1'b1;
    cyc(1);
    i_enable_cmd = 1'b0;
  endtask
  task automatic pulse_dis();
    i_disable_cmd = 1'b1;
    cyc(1);
    i_disable_cmd = 1'b0;
  endtask
  task automatic pulse_srst();
    i_soft_reset_bit = 1'b1;
    cyc(1);
    i_soft_reset_bit = 1'b0;
    cyc(3);
  endtask
  task automatic wait_idle(int lim);
    int q;
    q = 0;
    while (q < 20 && lim > 0) begin
      cyc(1);
      lim--;
      q = (o_busy === 1'b0) ? q + 1 : 0;
    end
    if (lim == 0) check_bit("busy", 1'b0, 1'b1);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (60000) @(posedge i_clock);
    errors++;
    give_verdict();
  end
  initial begin
    {i_enable_cmd, i_disable_cmd, i_soft_reset_bit, i_thr_write, i_sck, i_mosi} = '0;
    {i_clock_polarity_select, i_clock_phase_select, i_keep_select_after_transfer} = '0;
    {i_cs_sel, i_thr_data, tog} = '0;
    {i_rst, i_ss_n, i_rx_ready, i_master_mode} = 4'hF;
    i_fault_detect_disable = 1'b1;
    i_chip_select_active = 4'h1;
    i_serial_clock_divisor = {4{8'h10}};
    cyc(10);
    i_rst = 1'b0;
    cyc(2);
    check_bit("empty", 1'b1, o_transmit_holding_empty);
    // Slave mode ignores disable; soft reset stops it
    i_master_mode = 1'b0;
    pulse_en();
    cyc(3);
    pulse_dis();
    cyc(4);
    check_bit("enabled", 1'b1, o_enabled);
    // The disabled slave still takes a byte from its master
    rx_q.delete();
    sb = seed[7:0];
    i_ss_n = 1'b0;
    for (k = 7; k >= 0; k--) begin
      i_mosi = sb[k];
      cyc(2);
      i_sck = 1'b1;
      cyc(2);
      i_sck = 1'b0;
    end
    check_bit("miso_oe_n", 1'b0, o_miso_oe_n);
    check_bit("miso", 1'b0, o_miso);
    cyc(20);
    i_ss_n = 1'b1;
    check_val("slave count", 16'd1, 16'(rx_q.size()));
    check_val("slave word", {8'h00, sb}, {8'h00, rx_q[0]});
    pulse_srst();
    check_bit("enabled", 1'b0, o_enabled);
    i_master_mode = 1'b1;
    // Writes while disabled vanish
    wr(3);
    cyc(4);
    check_bit("empty", 1'b1, o_transmit_holding_empty);
    pulse_en();
    cyc(50);
    check_bit("busy", 1'b0, o_busy);
    // Fill past capacity with random data while the reader stalls at random
    rx_q.delete();
    wr_q.delete();
    mo_q.delete();
    base = frames;
    wr(36);
    cyc(3);
    check_bit("empty", 1'b0, o_transmit_holding_empty);
    wait_idle(20000);
    cyc(20);
    check_bit("empty", 1'b1, o_transmit_holding_empty);
    check_val("rx count", 16'd33, 16'(rx_q.size()));
    foreach (rx_q[i]) check_val("rx word", (base[0] ^ i[0]) ? 16'h00FF : 16'h0000, {8'h00, rx_q[i]});
    check_val("tx count", 16'd33, 16'(mo_q.size()));
    foreach (mo_q[i]) check_val("tx word", {8'h00, wr_q[i]}, {8'h00, mo_q[i]});
    // Stop feeding, pause, then disable with words queued
    wr(3);
    cyc(2);
    pulse_dis();
    cyc(5);
    check_bit("empty", 1'b0, o_transmit_holding_empty);
    pulse_srst();
    check_bit("empty", 1'b1, o_transmit_holding_empty);
    // Keep-select on select 0 with fault detection on never starts
    i_fault_detect_disable = 1'b0;
    i_keep_select_after_transfer = 4'h1;
    pulse_en();
    cyc(3);
    check_bit("fault", 1'b1, o_fault_unreliable);
    wr(1);
    cyc(200);
    check_bit("busy", 1'b0, o_busy);
    check_val("cs_n", 16'h000F, {12'h000, o_cs_n});
    check_bit("empty", 1'b0, o_transmit_holding_empty);
    pulse_srst();
    i_fault_detect_disable = 1'b1;
    i_keep_select_after_transfer = 4'h0;
    cyc(3);
    check_bit("fault", 1'b0, o_fault_unreliable);
    // Clock edge count for divisor mixes, warm-up transfer first
    i_chip_select_active = 4'h3;
    pulse_en();
    for (k = 0; k < 3; k++) begin
      i_serial_clock_divisor = (k == 0) ? {4{8'h01}} : {8'h02, 8'h02, 8'h02, 8'h01};
      i_clock_polarity_select = (k == 2) ? 4'h0 : 4'hF;
      cyc(3);
      wr(1);
      wait_idle(2000);
      tog = 0;
      wr(1);
      wait_idle(2000);
      check_val("sck toggles", (k == 1) ? 16'd18 : 16'd16, 16'(tog));
    end
    pulse_dis();
    cyc(3);
    check_bit("enabled", 1'b0, o_enabled);
    give_verdict();
  end
endmodule
bind sqk_top sqk_top_props #(.NUM_CS(NUM_CS)) u_props (
  .i_clock                      (i_clock),
  .i_rst                        (i_rst),
  .i_enable_cmd                 (i_enable_cmd),
  .i_disable_cmd                (i_disable_cmd),
  .i_soft_reset_bit             (i_soft_reset_bit),
  .i_master_mode                (i_master_mode),
  .i_fault_detect_disable       (i_fault_detect_disable),
  .i_keep_select_after_transfer (i_keep_select_after_transfer),
  .i_thr_write                  (i_thr_write),
  .o_enabled                    (o_enabled),
  .o_transmit_holding_empty     (o_transmit_holding_empty),
  .o_busy                       (o_busy),
  .o_fault_unreliable           (o_fault_unreliable)
);
